// ===== ims_pkg.sv
// package for the i2c master stop / collision / rate divider block
// assumes a single pclk domain and an apb register bus
`default_nettype none
package ims_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_RELOAD = 8'h04;
	localparam logic [7:0] OFF_BUF    = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	// control register fields
	localparam int CTRL_ENABLE  = 0;
	localparam int CTRL_START   = 1;
	localparam int CTRL_RESTART = 2;
	localparam int CTRL_STOP    = 3;
	localparam int CTRL_RECV    = 4;
	localparam int CTRL_ACK     = 5;
	localparam int CTRL_ACKDATA = 6;
	localparam int CTRL_EVENTEN = 7;
	// status register fields
	localparam int ST_FULL     = 0;
	localparam int ST_CLASH    = 1;
	localparam int ST_COLL     = 2;
	localparam int ST_EVENT    = 3;
	localparam int ST_STOPSEEN = 4;
	localparam int ST_STRTSEEN = 5;
	localparam int ST_TXACT    = 6;
	localparam int ST_ACTIVE   = 7;
	localparam int ST_ACKSTAT  = 8;
	localparam int ST_BUSFREE  = 9;
	// reset values
	localparam logic [7:0] RELOAD_RST = 8'h13;
	// bit index of the acknowledge slot and last received bit
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] RX_LAST  = 4'h7;
	// two sampled bus lines
	typedef struct packed {
		logic scl;
		logic sda;
	} ims_lines_t;
	// byte sequence kind
	typedef enum logic [1:0] {
		M_TX,
		M_RX,
		M_ACK
	} ims_mode_t;
endpackage : ims_pkg
`default_nettype wire

// ===== ims_core.sv
// i2c master stop, restart, start, byte and collision logic with rate divider
// assumes open-drain scl/sda with external pull-ups and an apb master on pclk
//
// Overview of operation
// R01 - after ninth falling edge scl stays low; stop begins by pulling sda low
// R02 - sda seen low: divider counts, scl released, one period later sda released
// R03 - sda high with scl high sets stop_seen; one period later stop ends, event
// R04 - buffer write during a stop is dropped and sets write_clash_flag
// R05 - in sleep, completed byte events wake the processor when enabled
// R06 - reset disables the port and abandons any transfer
// R07 - start_seen and stop_seen clear on reset and while disabled
// R08 - bus free when stop_seen set or both flags clear; stop raises event
// R09 - sda compared with driven level; mismatch sets collision_flag
// R10 - released sda read low with scl high: collision, port goes idle
// R11 - collision in a byte: stop, clear buffer_full, release lines
// R12 - collision in a sequence: abandon, release lines, clear request bit
// R13 - after collision a bus stop raises the port event flag
// R14 - buffer write after collision restarts at the first data bit
// R15 - start collides if a line is low at begin or scl low early
// R16 - start: sda low early or at count end, then scl low after second count
// R17 - restart: sda released, count, scl released, sda low at scl high collides
// R18 - restart high count: sda fall fine, scl fall before our sda low collides
// R19 - restart: both high at timeout, sda low, count, then scl low
// R20 - stop: scl high then count; sda low at timeout or early scl low collides
// R21 - divider reloads from divider_reload, starts on buffer write, twice per period
// R22 - scl rate is pclk over four times reload plus one; reload 0..2 forbidden
// R23 - lines are never driven high; samples come from synchronised pins
// R24 - request bits ORed with transmit activity show the port active
//
// Added by the designer: the register addresses and the APB register port.
`default_nettype none
module ims_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sleep_mode,
	output logic             wake_req,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe_n,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n
);
	typedef enum logic [3:0] {
		S_IDLE, S_ST1, S_ST2, S_RS1, S_RS2, S_RS3, S_RS4,
		S_SP0, S_SP1, S_SP2, S_SP3, S_SP4, S_SP5, S_BLO, S_BHI
	} ims_state_t;

	ims_state_t          state;
	ims_pkg::ims_mode_t  mode;
	ims_pkg::ims_lines_t sync1, sync2, prev;
	logic [7:0]  ctrl_bits;
	logic [7:0]  divider_reload;
	logic [7:0]  transfer_buffer;
	logic [7:0]  shreg;
	logic [8:0]  cnt;
	logic [3:0]  bitn;
	logic        sda_lo, scl_lo, ack_status;
	logic        buffer_full_flag, write_clash_flag, collision_flag, port_event_flag;
	logic        stop_seen_bit, start_seen_bit;
	logic        ev_coll, ev_done, ev_rx, ev_txdone;
	logic        wr, rd_ok, buf_wr, buf_take, busy, tmo, drive_bit, active, bus_free;
	logic        sda_i, scl_i, start_det, stop_det, enable, req_go;
	logic [8:0]  ld;

	// apb decode, zero wait states
	assign wr       = psel && penable && pwrite;
	assign pready   = 1'b1;
	assign rd_ok    = (paddr == ims_pkg::OFF_CTRL) || (paddr == ims_pkg::OFF_RELOAD) ||
		(paddr == ims_pkg::OFF_BUF) || (paddr == ims_pkg::OFF_STATUS);
	assign pslverr  = psel && penable && !rd_ok;
	assign buf_wr   = wr && (paddr == ims_pkg::OFF_BUF);
	assign busy     = (state != S_IDLE);
	assign buf_take = buf_wr && !busy && enable;
	assign enable   = ctrl_bits[ims_pkg::CTRL_ENABLE];

	// port active indication [R24]
	assign active = |ctrl_bits[ims_pkg::CTRL_ACK:ims_pkg::CTRL_START] ||
		(busy && mode == ims_pkg::M_TX);
	assign bus_free = stop_seen_bit || (!start_seen_bit && !stop_seen_bit); // [R08]
	assign wake_req = sleep_mode && port_event_flag && ctrl_bits[ims_pkg::CTRL_EVENTEN]; // [R05]

	// read data mux
	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			ims_pkg::OFF_CTRL:   prdata[7:0] = ctrl_bits;
			ims_pkg::OFF_RELOAD: prdata[7:0] = divider_reload;
			ims_pkg::OFF_BUF:    prdata[7:0] = transfer_buffer;
			ims_pkg::OFF_STATUS: begin
				prdata[ims_pkg::ST_FULL]     = buffer_full_flag;
				prdata[ims_pkg::ST_CLASH]    = write_clash_flag;
				prdata[ims_pkg::ST_COLL]     = collision_flag;
				prdata[ims_pkg::ST_EVENT]    = port_event_flag;
				prdata[ims_pkg::ST_STOPSEEN] = stop_seen_bit;
				prdata[ims_pkg::ST_STRTSEEN] = start_seen_bit;
				prdata[ims_pkg::ST_TXACT]    = busy && mode == ims_pkg::M_TX;
				prdata[ims_pkg::ST_ACTIVE]   = active;
				prdata[ims_pkg::ST_ACKSTAT]  = ack_status;
				prdata[ims_pkg::ST_BUSFREE]  = bus_free;
			end
			default: prdata = 32'h0000_0000;
		endcase
	end

	// pin synchronisers plus one history stage [R23]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 2'h3;
			sync2 <= 2'h3;
			prev  <= 2'h3;
		end else begin
			sync1 <= '{scl: scl_in, sda: sda_in};
			sync2 <= sync1;
			prev  <= sync2;
		end
	end
	assign sda_i     = sync2.sda;
	assign scl_i     = sync2.scl;
	assign start_det = prev.scl && scl_i && prev.sda && !sda_i;
	assign stop_det  = prev.scl && scl_i && !prev.sda && sda_i;

	// open-drain drivers: only ever pull low [R23]
	assign scl_out  = 1'b0;
	assign sda_out  = 1'b0;
	assign scl_oe_n = !scl_lo;
	assign sda_oe_n = !sda_lo;

	// divider reload, period of 2*(reload+1) pclk per half bus clock [R21] [R22]
	assign ld  = {divider_reload, 1'b1};
	assign tmo = (cnt == 9'h000);

	// level expected on sda for the current bit slot; the ack slot is the slave's [R09]
	always_comb begin
		drive_bit = 1'b1;
		unique case (mode)
			ims_pkg::M_TX:  drive_bit = (bitn == ims_pkg::ACK_SLOT) ? 1'b0 : shreg[7];
			ims_pkg::M_RX:  drive_bit = 1'b1;
			ims_pkg::M_ACK: drive_bit = ctrl_bits[ims_pkg::CTRL_ACKDATA];
		endcase
	end

	// reload register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			divider_reload <= ims_pkg::RELOAD_RST;
		else if (wr && paddr == ims_pkg::OFF_RELOAD)
			divider_reload <= pwdata[7:0];
	end

	// sequencer: lines, divider, bit counter, request bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= S_IDLE; // [R06]
			mode       <= ims_pkg::M_TX;
			ctrl_bits  <= 8'h00;
			shreg      <= 8'h00;
			cnt        <= 9'h000;
			bitn       <= 4'h0;
			sda_lo     <= 1'b0;
			scl_lo     <= 1'b0;
			ack_status <= 1'b0;
			ev_coll    <= 1'b0;
			ev_done    <= 1'b0;
			ev_rx      <= 1'b0;
			ev_txdone  <= 1'b0;
		end else begin
			ev_coll   <= 1'b0;
			ev_done   <= 1'b0;
			ev_rx     <= 1'b0;
			ev_txdone <= 1'b0;
			if (!tmo)
				cnt <= cnt - 9'h001;
			unique case (state)
				S_IDLE: begin
					if (buf_take) begin
						// new byte always starts at bit zero [R14] [R21]
						shreg  <= pwdata[7:0];
						mode   <= ims_pkg::M_TX;
						bitn   <= 4'h0;
						scl_lo <= 1'b1;
						sda_lo <= !pwdata[7];
						cnt    <= ld;
						state  <= S_BLO;
					end else if (req_go && ctrl_bits[ims_pkg::CTRL_START]) begin
						if (!sda_i || !scl_i) begin
							ev_coll <= 1'b1; // [R15]
						end else begin
							cnt   <= ld;
							state <= S_ST1;
						end
					end else if (req_go && ctrl_bits[ims_pkg::CTRL_RESTART]) begin
						sda_lo <= 1'b0; // [R17]
						cnt    <= ld;
						state  <= S_RS1;
					end else if (req_go && ctrl_bits[ims_pkg::CTRL_STOP]) begin
						sda_lo <= 1'b1; // [R01]
						scl_lo <= 1'b1;
						state  <= S_SP0;
					end else if (req_go && ctrl_bits[ims_pkg::CTRL_RECV]) begin
						mode   <= ims_pkg::M_RX;
						bitn   <= 4'h0;
						scl_lo <= 1'b1;
						sda_lo <= 1'b0;
						cnt    <= ld;
						state  <= S_BLO;
					end else if (req_go && ctrl_bits[ims_pkg::CTRL_ACK]) begin
						mode   <= ims_pkg::M_ACK;
						bitn   <= 4'h0;
						scl_lo <= 1'b1;
						sda_lo <= !ctrl_bits[ims_pkg::CTRL_ACKDATA];
						cnt    <= ld;
						state  <= S_BLO;
					end
				end
				// start, first count: early sda low or at count end [R16]
				S_ST1: begin
					if (!scl_i && sda_i) begin
						ev_coll <= 1'b1; // [R15]
					end else if (!sda_i || tmo) begin
						sda_lo <= 1'b1; // [R16]
						cnt    <= ld;
						state  <= S_ST2;
					end
				end
				S_ST2: if (tmo) begin
					scl_lo  <= 1'b1; // scl low here is no collision [R16]
					ev_done <= 1'b1;
					state   <= S_IDLE;
				end
				S_RS1: if (tmo) begin
					scl_lo <= 1'b0; // [R17]
					state  <= S_RS2;
				end
				S_RS2: if (scl_i) begin
					if (!sda_i) begin
						ev_coll <= 1'b1; // [R17]
					end else begin
						cnt   <= ld;
						state <= S_RS3;
					end
				end
				S_RS3: begin
					if (tmo) begin
						sda_lo <= 1'b1; // [R19]
						cnt    <= ld;
						state  <= S_RS4;
					end else if (!scl_i) begin
						ev_coll <= 1'b1; // [R18]
					end
				end
				S_RS4: if (tmo) begin
					scl_lo  <= 1'b1; // [R19]
					ev_done <= 1'b1;
					state   <= S_IDLE;
				end
				S_SP0: if (!sda_i) begin
					cnt   <= ld; // [R02]
					state <= S_SP1;
				end
				S_SP1: if (tmo) begin
					scl_lo <= 1'b0; // [R02]
					state  <= S_SP2;
				end
				S_SP2: if (scl_i) begin
					cnt   <= ld; // [R20]
					state <= S_SP3;
				end
				S_SP3: begin
					if (!scl_i) begin
						ev_coll <= 1'b1; // [R20]
					end else if (tmo) begin
						sda_lo <= 1'b0; // [R02]
						cnt    <= ld;
						state  <= S_SP4;
					end
				end
				S_SP4: if (tmo) begin
					if (!sda_i) begin
						ev_coll <= 1'b1; // [R20]
					end else begin
						cnt   <= ld; // [R03]
						state <= S_SP5;
					end
				end
				S_SP5: if (tmo) begin
					ev_done <= 1'b1; // [R03]
					state   <= S_IDLE;
				end
				// byte bit, scl low half
				S_BLO: if (tmo) begin
					scl_lo <= 1'b0;
					cnt    <= ld;
					state  <= S_BHI;
				end
				// byte bit, scl high half; stretched scl reloads the count
				S_BHI: begin
					if (!scl_i) begin
						cnt <= ld;
					end else if (mode != ims_pkg::M_RX && drive_bit && !sda_i) begin
						ev_coll <= 1'b1; // [R09] [R10]
					end else if (tmo) begin
						scl_lo <= 1'b1; // [R01]
						cnt    <= ld;
						if (mode == ims_pkg::M_RX)
							shreg <= {shreg[6:0], sda_i};
						else if (bitn != ims_pkg::ACK_SLOT)
							shreg <= {shreg[6:0], 1'b0};
						if (mode == ims_pkg::M_TX && bitn == ims_pkg::ACK_SLOT) begin
							ack_status <= sda_i;
							sda_lo     <= 1'b0;
							ev_txdone  <= 1'b1;
							ev_done    <= 1'b1;
							state      <= S_IDLE;
						end else if (mode == ims_pkg::M_RX && bitn == ims_pkg::RX_LAST) begin
							ev_rx   <= 1'b1;
							ev_done <= 1'b1;
							state   <= S_IDLE;
						end else if (mode == ims_pkg::M_ACK) begin
							sda_lo  <= 1'b0;
							ev_done <= 1'b1;
							state   <= S_IDLE;
						end else begin
							bitn   <= bitn + 4'h1;
							sda_lo <= (mode == ims_pkg::M_TX) &&
								(bitn != ims_pkg::RX_LAST) && !shreg[6];
							state  <= S_BLO;
						end
					end
				end
			endcase
			// finished or collided sequence clears its request bit [R03] [R12]
			if (ev_coll || ev_done)
				ctrl_bits[ims_pkg::CTRL_ACK:ims_pkg::CTRL_START] <= 5'h00;
			// collision: release both lines and go idle, unless a new byte is taken [R10] [R11] [R12]
			if (ev_coll && !buf_take) begin
				sda_lo <= 1'b0;
				scl_lo <= 1'b0;
				state  <= S_IDLE;
			end
			// software write, request bits written only while idle; wins over the clear
			if (wr && paddr == ims_pkg::OFF_CTRL) begin
				ctrl_bits[ims_pkg::CTRL_ENABLE]  <= pwdata[ims_pkg::CTRL_ENABLE];
				ctrl_bits[ims_pkg::CTRL_ACKDATA] <= pwdata[ims_pkg::CTRL_ACKDATA];
				ctrl_bits[ims_pkg::CTRL_EVENTEN] <= pwdata[ims_pkg::CTRL_EVENTEN];
				if (!busy)
					ctrl_bits[ims_pkg::CTRL_ACK:ims_pkg::CTRL_START] <=
						pwdata[ims_pkg::CTRL_ACK:ims_pkg::CTRL_START];
			end
			// disabled port abandons any transfer [R06]
			if (!enable) begin
				state  <= S_IDLE;
				sda_lo <= 1'b0;
				scl_lo <= 1'b0;
			end
		end
	end

	// requests wait out the cycle in which the last event clears them
	assign req_go = enable && !ev_coll && !ev_done;

	// status flags and transfer buffer; hardware set beats software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transfer_buffer  <= 8'h00;
			buffer_full_flag <= 1'b0;
			write_clash_flag <= 1'b0;
			collision_flag   <= 1'b0;
			port_event_flag  <= 1'b0;
			stop_seen_bit    <= 1'b0;
			start_seen_bit   <= 1'b0;
		end else begin
			if (wr && paddr == ims_pkg::OFF_STATUS) begin
				if (pwdata[ims_pkg::ST_CLASH])
					write_clash_flag <= 1'b0;
				if (pwdata[ims_pkg::ST_COLL])
					collision_flag <= 1'b0;
				if (pwdata[ims_pkg::ST_EVENT])
					port_event_flag <= 1'b0;
			end
			if (buf_wr && busy)
				write_clash_flag <= 1'b1; // [R04]
			if (ev_txdone || ev_coll)
				buffer_full_flag <= 1'b0; // [R11]
			// a new byte after a collision wins over the clear [R11]
			if (buf_take) begin
				transfer_buffer  <= pwdata[7:0];
				buffer_full_flag <= 1'b1;
			end
			if (ev_rx) begin
				transfer_buffer  <= shreg;
				buffer_full_flag <= 1'b1;
			end
			if (ev_coll)
				collision_flag <= 1'b1; // [R09]
			// own sequence done, or a bus stop while idle [R08] [R13] [R05]
			if (ev_done || (stop_det && !busy))
				port_event_flag <= 1'b1;
			if (start_det) begin
				start_seen_bit <= 1'b1;
				stop_seen_bit  <= 1'b0;
			end
			if (stop_det) begin
				stop_seen_bit  <= 1'b1; // [R03]
				start_seen_bit <= 1'b0;
			end
			if (!enable) begin
				stop_seen_bit  <= 1'b0; // [R07]
				start_seen_bit <= 1'b0;
			end
		end
	end

	clash_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
		buf_wr && busy |=> write_clash_flag && $stable(transfer_buffer))
		else $error("buffer changed on write during sequence");
	coll_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
		ev_coll && !buf_take |=> (state == S_IDLE) && !sda_lo && !scl_lo)
		else $error("collision did not release lines");
	coll_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
		ev_coll |=> collision_flag)
		else $error("collision flag not set");
	full_drop_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		ev_coll && !buf_take |=> !buffer_full_flag)
		else $error("buffer full not cleared on collision");
	start_coll_a: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
		state == S_IDLE && !buf_take && req_go && ctrl_bits[ims_pkg::CTRL_START] &&
		(!sda_i || !scl_i) |=> ##1 collision_flag)
		else $error("start on busy lines not flagged");
	seen_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
		!enable |=> !stop_seen_bit && !start_seen_bit)
		else $error("seen flags kept while disabled");
	stop_end_a: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
		state == S_SP5 && tmo && enable |=> ##1 port_event_flag &&
		!ctrl_bits[ims_pkg::CTRL_STOP])
		else $error("stop did not finish");
	restart_end_a: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
		state == S_RS4 && tmo && enable |=> scl_lo && state == S_IDLE)
		else $error("restart did not pull scl low");
	first_bit_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		buf_take |=> state == S_BLO && bitn == 4'h0 && sda_lo == !transfer_buffer[7])
		else $error("byte did not restart at first bit");
endmodule : ims_core
`default_nettype wire

// ===== ims_peer.sv
// far-side bus party: another master or slave able to pull scl or sda low
// assumes the bench resolves each line from all open-drain enables plus a pull-up
`default_nettype none
module ims_peer (
	input  wire logic pclk,
	input  wire logic pull_sda,
	input  wire logic pull_scl,
	output logic      sda_oe_n,
	output logic      scl_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// only ever pulls low or lets go, changed just after a clock edge
	always_ff @(posedge pclk) begin
		sda_oe_n <= !pull_sda;
		scl_oe_n <= !pull_scl;
	end
endmodule : ims_peer
`default_nettype wire

// ===== i2c_master_stop_collision_brg_bench.sv
// self-checking bench for the i2c master stop, collision and divider block
// assumes ims_pkg, ims_core and ims_peer compiled first; pull-ups on both lines
`default_nettype none
module i2c_master_stop_collision_brg_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sleep_mode = 1'h0;
	logic        wake_req;
	logic        dut_scl_oe_n;
	logic        dut_sda_oe_n;
	logic        dut_scl_out;
	logic        dut_sda_out;
	logic        peer_scl_oe_n;
	logic        peer_sda_oe_n;
	logic        pull_sda = 1'h0;
	logic        pull_scl = 1'h0;
	wire         scl_line;
	wire         sda_line;
	int          err_count = 0;
	int          checked = 0;
	int          cnt;
	logic [31:0] rd;
	logic        err_seen;

	// wired-and of both parties with pull-ups
	assign scl_line = (dut_scl_oe_n === 1'h0 || peer_scl_oe_n === 1'h0) ? 1'h0 : 1'h1;
	assign sda_line = (dut_sda_oe_n === 1'h0 || peer_sda_oe_n === 1'h0) ? 1'h0 : 1'h1;

	// 100 MHz clock
	always #5 pclk = ~pclk;

	ims_core dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode),
		.wake_req(wake_req), .scl_in(scl_line), .scl_out(dut_scl_out),
		.scl_oe_n(dut_scl_oe_n), .sda_in(sda_line), .sda_out(dut_sda_out),
		.sda_oe_n(dut_sda_oe_n)
	);

	ims_peer peer_u (
		.pclk(pclk), .pull_sda(pull_sda), .pull_scl(pull_scl),
		.sda_oe_n(peer_sda_oe_n), .scl_oe_n(peer_scl_oe_n)
	);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one apb transfer: setup, access until pready, then release
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= data;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		rd = prdata;
		err_seen = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb

	// poll status until a bit sets, bounded
	task automatic wait_st(input int idx);
		int n;
		n = 0;
		do begin
			apb(1'h0, ims_pkg::OFF_STATUS, 32'h0);
			n++;
		end while (rd[idx] !== 1'h1 && n < 200);
		if (rd[idx] !== 1'h1) begin
			err_count++;
			$display("[FAIL] status bit %0d wait expected 1 seen %b", idx, rd[idx]);
		end
	endtask : wait_st

	task automatic wait_oe(input logic on_sda, input logic val);
		cnt = 0;
		while ((on_sda ? dut_sda_oe_n : dut_scl_oe_n) !== val && cnt < 400) begin
			@(posedge pclk);
			cnt++;
		end
		if (cnt >= 400) begin
			err_count++;
			$display("[FAIL] line enable wait expected %b seen %b", val, !val);
		end
	endtask : wait_oe

	task automatic t_reset();
		apb(1'h0, ims_pkg::OFF_RELOAD, 32'h0);
		check("reload reset", rd, 32'h13);
		apb(1'h0, ims_pkg::OFF_STATUS, 32'h0);
		check("status flags", {23'h0, rd[8:0]}, 32'h0);
		check("bus free", rd[ims_pkg::ST_BUSFREE], 32'h1);
		check("lines idle", {dut_scl_oe_n, dut_sda_oe_n}, 32'h3);
		check("drive level", {dut_scl_out, dut_sda_out}, 32'h0);
		apb(1'h0, 8'h10, 32'h0);
		check("unmapped err", {rd[30:0], err_seen}, 32'h1);
	endtask : t_reset

	task automatic t_start_coll();
		apb(1'h1, ims_pkg::OFF_RELOAD, 32'h3);
		pull_scl <= 1'h1;
		repeat (4) @(posedge pclk);
		apb(1'h1, ims_pkg::OFF_CTRL, 32'h3);
		wait_st(ims_pkg::ST_COLL);
		check("start coll", rd[ims_pkg::ST_COLL], 32'h1);
		apb(1'h0, ims_pkg::OFF_CTRL, 32'h0);
		check("start cleared", rd, 32'h1);
		check("lines freed", {dut_scl_oe_n, dut_sda_oe_n}, 32'h3);
		pull_scl <= 1'h0;
		apb(1'h1, ims_pkg::OFF_STATUS, 32'hE);
	endtask : t_start_coll

	task automatic t_stop();
		apb(1'h1, ims_pkg::OFF_CTRL, 32'h9);
		apb(1'h1, ims_pkg::OFF_BUF, 32'hA5);
		check("stop sda low", dut_sda_oe_n, 32'h0);
		apb(1'h0, ims_pkg::OFF_STATUS, 32'h0);
		check("clash", rd[ims_pkg::ST_CLASH], 32'h1);
		check("no fill", rd[ims_pkg::ST_FULL], 32'h0);
		check("active", rd[ims_pkg::ST_ACTIVE], 32'h1);
		wait_oe(1'h1, 1'h1);
		check("scl first", dut_scl_oe_n, 32'h1);
		wait_st(ims_pkg::ST_EVENT);
		check("stop seen", rd[ims_pkg::ST_STOPSEEN], 32'h1);
		check("free after", rd[ims_pkg::ST_BUSFREE], 32'h1);
		apb(1'h0, ims_pkg::OFF_CTRL, 32'h0);
		check("stop self clr", rd, 32'h1);
		apb(1'h1, ims_pkg::OFF_STATUS, 32'hE);
	endtask : t_stop

	task automatic t_stop_coll();
		pull_sda <= 1'h1;
		repeat (4) @(posedge pclk);
		apb(1'h1, ims_pkg::OFF_CTRL, 32'h9);
		wait_st(ims_pkg::ST_COLL);
		check("stop coll", rd[ims_pkg::ST_COLL], 32'h1);
		apb(1'h0, ims_pkg::OFF_CTRL, 32'h0);
		check("stop dropped", rd, 32'h1);
		apb(1'h1, ims_pkg::OFF_STATUS, 32'hE);
		pull_sda <= 1'h0;
		repeat (8) @(posedge pclk);
		apb(1'h0, ims_pkg::OFF_STATUS, 32'h0);
		check("bus stop event", rd[ims_pkg::ST_EVENT], 32'h1);
		apb(1'h1, ims_pkg::OFF_CTRL, 32'h81);
		sleep_mode <= 1'h1;
		repeat (2) @(posedge pclk);
		check("wake", wake_req, 32'h1);
		apb(1'h1, ims_pkg::OFF_STATUS, 32'hE);
		check("no wake", wake_req, 32'h0);
		sleep_mode <= 1'h0;
	endtask : t_stop_coll

	task automatic t_byte();
		apb(1'h1, ims_pkg::OFF_CTRL, 32'h3);
		wait_oe(1'h1, 1'h0);
		wait_oe(1'h0, 1'h0);
		check("start hold", 32'(cnt >= 7 && cnt <= 10), 32'h1);
		wait_st(ims_pkg::ST_EVENT);
		apb(1'h1, ims_pkg::OFF_STATUS, 32'hE);
		pull_sda <= 1'h1;
		apb(1'h1, ims_pkg::OFF_BUF, 32'hFF);
		wait_st(ims_pkg::ST_COLL);
		check("byte coll", rd[ims_pkg::ST_COLL], 32'h1);
		check("full cleared", rd[ims_pkg::ST_FULL], 32'h0);
		check("idle", rd[ims_pkg::ST_ACTIVE], 32'h0);
		check("lines freed", {dut_scl_oe_n, dut_sda_oe_n}, 32'h3);
		pull_sda <= 1'h0;
		repeat (8) @(posedge pclk);
		apb(1'h1, ims_pkg::OFF_STATUS, 32'hE);
		apb(1'h1, ims_pkg::OFF_BUF, 32'h7F);
		apb(1'h0, ims_pkg::OFF_STATUS, 32'h0);
		check("refill", rd[ims_pkg::ST_FULL], 32'h1);
		wait_oe(1'h1, 1'h0);
		check("first bit", dut_sda_oe_n, 32'h0);
		wait_st(ims_pkg::ST_EVENT);
		check("nack", rd[ims_pkg::ST_ACKSTAT], 32'h1);
		check("scl held", dut_scl_oe_n, 32'h0);
	endtask : t_byte

	// restart, receive and acknowledge from scl held low after a byte
	task automatic t_restart_rx();
		apb(1'h1, ims_pkg::OFF_STATUS, 32'hE);
		apb(1'h1, ims_pkg::OFF_CTRL, 32'h5);
		wait_st(ims_pkg::ST_EVENT);
		check("restart lines", {dut_scl_oe_n, dut_sda_oe_n}, 32'h0);
		apb(1'h0, ims_pkg::OFF_CTRL, 32'h0);
		check("restart clr", rd, 32'h1);
		apb(1'h1, ims_pkg::OFF_STATUS, 32'hE);
		apb(1'h1, ims_pkg::OFF_CTRL, 32'h11);
		wait_st(ims_pkg::ST_EVENT);
		check("rx full", rd[ims_pkg::ST_FULL], 32'h1);
		apb(1'h0, ims_pkg::OFF_BUF, 32'h0);
		check("rx byte", rd, 32'hFF);
		check("rx scl held", dut_scl_oe_n, 32'h0);
		apb(1'h1, ims_pkg::OFF_STATUS, 32'hE);
		apb(1'h1, ims_pkg::OFF_CTRL, 32'h21);
		wait_st(ims_pkg::ST_EVENT);
		check("ack idle", rd[ims_pkg::ST_ACTIVE], 32'h0);
	endtask : t_restart_rx

	task automatic t_disable();
		apb(1'h1, ims_pkg::OFF_CTRL, 32'h0);
		apb(1'h0, ims_pkg::OFF_STATUS, 32'h0);
		check("seen cleared", rd[5:4], 32'h0);
		apb(1'h1, ims_pkg::OFF_CTRL, 32'h3);
		repeat (6) @(posedge pclk);
		presetn <= 1'h0;
		@(posedge pclk);
		check("reset frees", {dut_scl_oe_n, dut_sda_oe_n}, 32'h3);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, ims_pkg::OFF_CTRL, 32'h0);
		check("ctrl cleared", rd, 32'h0);
	endtask : t_disable

	task automatic print_verdict();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset();
		t_start_coll();
		t_stop();
		t_stop_coll();
		t_byte();
		t_restart_rx();
		t_disable();
		print_verdict();
	end

	// watchdog against a hang
	initial begin
		#200000;
		err_count++;
		print_verdict();
	end
endmodule : i2c_master_stop_collision_brg_bench
`default_nettype wire
